// *** hdl/ipf_pkg.sv ***
// Constants shared by the input parity and FIFO latency block
package ipf_pkg;
    localparam int ADDR_W = 7;
    localparam logic [6:0] Q1_FALL_PATTERN_LOW_ADDR = 7'h67;
    localparam logic [6:0] Q1_FALL_PATTERN_HIGH_ADDR = 7'h68;
    localparam logic [6:0] PARITY_CONTROL_ADDR = 7'h6a;
    localparam logic [6:0] RISING_PARITY_ERROR_COUNT_ADDR = 7'h6b;
    localparam logic [6:0] FALLING_PARITY_ERROR_COUNT_ADDR = 7'h6c;
    localparam logic [6:0] CHIP_REVISION_ADDR = 7'h7f;
    localparam int PAR_ENABLE_BIT = 7;
    localparam int PAR_EVEN_BIT = 6;
    localparam int PAR_CLEAR_BIT = 5;
    localparam int PAR_FALL_FAULT_BIT = 1;
    localparam int PAR_RISE_FAULT_BIT = 0;
    localparam logic [7:0] PATTERN_RESET = 8'h00;
    localparam logic [7:0] PARITY_CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam int FIFO_SLOTS = 8;
    localparam logic [2:0] FIFO_DEPTH_RECOMMENDED = 3'h4;
    localparam int SYNC_STAGES = 3;
endpackage

// *** hdl/ipf_fifo.sv ***
// Eight-slot input FIFO with independent write and read side resets
module ipf_fifo
    import ipf_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = FIFO_SLOTS,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_valid_i,
    input wire logic [W-1:0] wr_data_i,
    output logic wr_ready_o,
    input wire logic rd_tick_i,
    input wire logic rd_ready_i,
    output logic rd_valid_o,
    output logic [W-1:0] rd_data_o,
    input wire logic wr_reset_i,
    input wire logic rd_reset_i,
    input wire logic depth_reset_i,
    input wire logic [AW-1:0] depth_i,
    output logic [AW:0] level_o
);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic [AW:0] next_level;
    logic push;
    logic pop;

    assign push = wr_valid_i && wr_ready_o;
    assign pop = rd_tick_i && (!rd_valid_o || rd_ready_i) && (wptr != rptr);

    // Pointers wrap slot 7 -> 0; the extra top bit tells full from empty
    always_comb begin // [R10]
        next_wptr = wptr;
        next_rptr = rptr;
        if (wr_reset_i) begin // [R15]
            next_wptr = '0;
        end else if (push) begin
            next_wptr = wptr + 1'b1;
        end
        if (depth_reset_i) begin // [R12]
            next_rptr = next_wptr - {1'b0, depth_i};
        end else if (rd_reset_i) begin // [R15]
            next_rptr = '0 - {1'b0, depth_i};
        end else if (pop) begin
            next_rptr = rptr + 1'b1;
        end
        next_level = next_wptr - next_rptr; // [R11]
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wptr <= '0;
            rptr <= '0;
            level_o <= '0;
            wr_ready_o <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            level_o <= next_level;
            wr_ready_o <= (next_level != FULL_LEVEL);
        end
    end

    // Slot contents are not reset: a depth reset exposes whatever sits there
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
        end else if (pop) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= mem[rptr[AW-1:0]];
        end else if (rd_ready_i) begin
            rd_valid_o <= 1'b0;
        end
    end

    AST_LEVEL_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        level_o <= FULL_LEVEL) // [R10]
        else $error("fifo level beyond slot count");

    AST_DEPTH_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        depth_reset_i |=> level_o == {1'b0, $past(depth_i)}) // [R12]
        else $error("depth reset did not set level");

    AST_WORD_STAYS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (depth_reset_i && !wr_reset_i) ##1 (!push && !pop && !rd_reset_i
        && !depth_reset_i && !wr_reset_i) |=> $stable(level_o)) // [R11]
        else $error("fifo depth drifted without traffic");
endmodule

// *** hdl/ipf_input_check.sv ***
// Input parity checking, comparison pattern store and FIFO latency control
// Operation
// R1 - 0x67 holds the writable low byte of the Q1 compare word, reset 0.
// R2 - 0x68 holds the writable high byte of that compare word, reset 0.
// R3 - Parity is checked only while enabled; polarity 0 is odd, 1 is even.
// R4 - Writing one to the clear bit zeroes both counters and both flags; an error in that same cycle still sets its flag and counts 1.
// R5 - A sticky flag rises on a parity error of a falling-edge sample.
// R6 - A sticky flag rises on a parity error of a rising-edge sample.
// R7 - An 8-bit saturating counter counts rising-edge (S0, S2) parity errors.
// R8 - An 8-bit saturating counter counts falling-edge (S1, S3) parity errors.
// R9 - A read-only register returns a fixed chip revision code.
// R10 - The FIFO has eight slots; its pointers wrap from slot 7 to 0.
// R11 - Depth is the read-to-write pointer distance and each word's stay.
// R12 - The depth is reset to a programmable nonzero value, four by default.
// R13 - Latency is undefined from power-up until a depth reset or sync.
// R14 - In 2x interpolation a half-rate clock reads the FIFO; phase is free.
// R15 - Frame and sync reset the FIFO write and read sides independently.
// R16 - The data sources keep data and data clocks aligned across devices.
module ipf_input_check
    import ipf_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int SLOTS = FIFO_SLOTS,
    parameter logic [7:0] CHIP_REVISION = 8'h5a // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic s_valid_i,
    input wire logic [DATA_W-1:0] s_data_i,
    input wire logic s_parity_i,
    output logic s_ready_o,
    output logic dac_valid_o,
    output logic [DATA_W-1:0] dac_data_o,
    input wire logic dac_ready_i,
    input wire logic frame_i,
    input wire logic sync_i,
    input wire logic interp2_i,
    input wire logic depth_reset_i,
    input wire logic [2:0] fifo_depth_i,
    output logic [3:0] fifo_level_o,
    output logic read_phase_o,
    output logic rising_parity_fault_o,
    output logic falling_parity_fault_o,
    output logic [DATA_W-1:0] q1_falling_compare_word_o
);
    // Register file
    logic [7:0] q1_fall_pattern_low;
    logic [7:0] q1_fall_pattern_high;
    logic par_enable;
    logic par_even;
    logic [7:0] rising_parity_error_count;
    logic [7:0] falling_parity_error_count;
    logic wr_pat_low;
    logic wr_pat_high;
    logic wr_ctrl;
    logic clear_wr;

    // Sample path
    logic accept;
    logic edge_fall;
    logic par_bad;
    logic rise_err;
    logic fall_err;

    // Reference pin synchronisers: stage 1 feeds only stage 2
    logic [1:0] ref_s1;
    logic [1:0] ref_s2;
    logic [1:0] ref_s3;
    logic [1:0] ref_level;
    logic [1:0] ref_prev;
    logic frame_rise;
    logic sync_rise;

    // Read side clocking
    logic div_phase;
    logic rd_tick;
    logic [2:0] depth_eff;

    assign wr_pat_low = reg_wr_i && (reg_addr_i == Q1_FALL_PATTERN_LOW_ADDR);
    assign wr_pat_high = reg_wr_i && (reg_addr_i == Q1_FALL_PATTERN_HIGH_ADDR);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == PARITY_CONTROL_ADDR);
    assign clear_wr = wr_ctrl && reg_wdata_i[PAR_CLEAR_BIT];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q1_fall_pattern_low <= PATTERN_RESET;
        end else if (wr_pat_low) begin
            q1_fall_pattern_low <= reg_wdata_i; // [R1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q1_fall_pattern_high <= PATTERN_RESET;
        end else if (wr_pat_high) begin
            q1_fall_pattern_high <= reg_wdata_i; // [R2]
        end
    end

    // Full word presented to the sample compare logic
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q1_falling_compare_word_o <= '0;
        end else begin
            q1_falling_compare_word_o <= DATA_W'({q1_fall_pattern_high,
                                                  q1_fall_pattern_low});
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            par_enable <= PARITY_CONTROL_RESET[PAR_ENABLE_BIT];
            par_even <= PARITY_CONTROL_RESET[PAR_EVEN_BIT];
        end else if (wr_ctrl) begin
            par_enable <= reg_wdata_i[PAR_ENABLE_BIT]; // [R3]
            par_even <= reg_wdata_i[PAR_EVEN_BIT]; // [R3]
        end
    end

    // Edge tag: words alternate rising, falling; a frame restarts at S0
    assign accept = s_valid_i && s_ready_o;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            edge_fall <= 1'b0;
        end else if (frame_rise) begin
            edge_fall <= 1'b0;
        end else if (accept) begin
            edge_fall <= !edge_fall;
        end
    end

    // Odd parity expects an odd count of ones over data and parity bit
    assign par_bad = par_enable && accept
                     && ((^{s_data_i, s_parity_i}) == par_even); // [R3]
    assign rise_err = par_bad && !edge_fall;
    assign fall_err = par_bad && edge_fall;

    // An error in the clear cycle survives: set wins over clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rising_parity_error_count <= COUNT_RESET;
        end else if (rise_err) begin
            if (clear_wr) begin
                rising_parity_error_count <= 8'h01;
            end else if (rising_parity_error_count != COUNT_MAX) begin
                rising_parity_error_count <=
                    rising_parity_error_count + 8'h01; // [R7]
            end
        end else if (clear_wr) begin
            rising_parity_error_count <= COUNT_RESET; // [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            falling_parity_error_count <= COUNT_RESET;
        end else if (fall_err) begin
            if (clear_wr) begin
                falling_parity_error_count <= 8'h01;
            end else if (falling_parity_error_count != COUNT_MAX) begin
                falling_parity_error_count <=
                    falling_parity_error_count + 8'h01; // [R8]
            end
        end else if (clear_wr) begin
            falling_parity_error_count <= COUNT_RESET; // [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rising_parity_fault_o <= 1'b0;
        end else if (rise_err) begin
            rising_parity_fault_o <= 1'b1; // [R6]
        end else if (clear_wr) begin
            rising_parity_fault_o <= 1'b0; // [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            falling_parity_fault_o <= 1'b0;
        end else if (fall_err) begin
            falling_parity_fault_o <= 1'b1; // [R5]
        end else if (clear_wr) begin
            falling_parity_fault_o <= 1'b0; // [R4]
        end
    end

    // Read data registered; clear bit and reserved bits read as zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                Q1_FALL_PATTERN_LOW_ADDR: reg_rdata_o <= q1_fall_pattern_low;
                Q1_FALL_PATTERN_HIGH_ADDR: reg_rdata_o <= q1_fall_pattern_high;
                PARITY_CONTROL_ADDR: reg_rdata_o <= {par_enable, par_even,
                    4'h0, falling_parity_fault_o, rising_parity_fault_o};
                RISING_PARITY_ERROR_COUNT_ADDR:
                    reg_rdata_o <= rising_parity_error_count;
                FALLING_PARITY_ERROR_COUNT_ADDR:
                    reg_rdata_o <= falling_parity_error_count;
                CHIP_REVISION_ADDR: reg_rdata_o <= CHIP_REVISION; // [R9]
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Frame and sync references come from other devices' timing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ref_s1 <= 2'h0;
            ref_s2 <= 2'h0;
            ref_s3 <= 2'h0;
            ref_level <= 2'h0;
            ref_prev <= 2'h0;
        end else begin
            ref_s1 <= {sync_i, frame_i};
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            ref_level <= (ref_level & ~(ref_s2 ^ ref_s3))
                         | (ref_s2 & ref_s3);
            ref_prev <= ref_level;
        end
    end

    assign frame_rise = ref_level[0] && !ref_prev[0];
    assign sync_rise = ref_level[1] && !ref_prev[1];

    // Divider phase is only pinned by a sync; otherwise it is free-running
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_phase <= 1'b0;
        end else if (sync_rise) begin
            div_phase <= 1'b0; // [R13]
        end else begin
            div_phase <= !div_phase; // [R14]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            read_phase_o <= 1'b0;
        end else begin
            read_phase_o <= div_phase;
        end
    end

    assign rd_tick = interp2_i ? div_phase : 1'b1; // [R14]

    // A zero depth would make the pointers collide; fall back to four
    assign depth_eff = (fifo_depth_i == 3'h0) ? FIFO_DEPTH_RECOMMENDED
                                              : fifo_depth_i; // [R12]

    ipf_fifo #(
        .W(DATA_W),
        .DEPTH(SLOTS)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_valid_i(s_valid_i),
        .wr_data_i(s_data_i),
        .wr_ready_o(s_ready_o),
        .rd_tick_i(rd_tick),
        .rd_ready_i(dac_ready_i),
        .rd_valid_o(dac_valid_o),
        .rd_data_o(dac_data_o),
        .wr_reset_i(frame_rise), // [R15]
        .rd_reset_i(sync_rise), // [R15]
        .depth_reset_i(depth_reset_i), // [R13]
        .depth_i(depth_eff),
        .level_o(fifo_level_o)
    );

    AST_PAT_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_pat_low |=> q1_fall_pattern_low == $past(reg_wdata_i)) // [R1]
        else $error("pattern low byte not stored");

    AST_PAT_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_pat_high |=> ##1 q1_falling_compare_word_o[15:8]
        == $past(reg_wdata_i, 2)) // [R2]
        else $error("pattern high byte not in compare word");

    AST_PARITY_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!par_enable && !clear_wr) |=> $stable(rising_parity_error_count)
        && $stable(falling_parity_error_count)) // [R3]
        else $error("counter moved with parity disabled");

    AST_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clear_wr && !par_bad) |=> rising_parity_error_count == 8'h00
        && falling_parity_error_count == 8'h00 && !rising_parity_fault_o
        && !falling_parity_fault_o) // [R4]
        else $error("parity clear incomplete");

    AST_FALL_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fall_err |=> falling_parity_fault_o
        && falling_parity_error_count != 8'h00) // [R5]
        else $error("falling error not flagged");

    AST_RISE_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (par_enable && accept && !edge_fall
        && ((^{s_data_i, s_parity_i}) == par_even))
        |=> rising_parity_fault_o) // [R6]
        else $error("rising error not flagged");

    AST_RISE_SAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rising_parity_error_count == 8'hff && !clear_wr)
        |=> rising_parity_error_count == 8'hff) // [R7]
        else $error("rising counter wrapped");

    AST_FALL_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fall_err && !clear_wr && falling_parity_error_count != 8'hff)
        |=> falling_parity_error_count
        == $past(falling_parity_error_count) + 8'h01) // [R8]
        else $error("falling counter missed an error");

    AST_VERSION: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == CHIP_REVISION_ADDR)
        |=> reg_rdata_o == CHIP_REVISION) // [R9]
        else $error("revision read wrong");

    AST_DIVIDER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (interp2_i && !sync_rise) ##1 (interp2_i && !sync_rise)
        |-> div_phase != $past(div_phase)) // [R14]
        else $error("half-rate divider stalled");

    AST_SYNC_DEPTH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sync_rise && frame_rise && !depth_reset_i)
        |=> fifo_level_o == {1'b0, $past(depth_eff)}) // [R15]
        else $error("frame and sync did not set depth");
endmodule

// *** tb/ipf_source_model.sv ***
// Behavioural sample word source standing in for the external data logic
module ipf_source_model (
    input wire logic clk_i,
    input wire logic s_ready_i,
    input wire logic even_i,
    output logic s_valid_o,
    output logic [15:0] s_data_o,
    output logic s_parity_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        s_valid_o = 1'b0;
        s_data_o = 16'h0000;
        s_parity_o = 1'b0;
    end

    // Word and parity are held until taken; the idle bus shows the inverse
    // so a stale word never passes for a fresh one
    task automatic send(input logic [15:0] d, input logic bad, input int gap);
        repeat (gap + 1) @(posedge clk_i);
        s_valid_o <= 1'b1;
        s_data_o <= d;
        s_parity_o <= (^d) ^ ~even_i ^ bad;
        @(posedge clk_i);
        while (s_ready_i !== 1'b1) @(posedge clk_i);
        s_valid_o <= 1'b0;
        s_data_o <= ~d;
        s_parity_o <= ~((^d) ^ ~even_i ^ bad);
    endtask
endmodule

// *** tb/ipf_input_check_tb.sv ***
// Self-checking bench for the input parity and FIFO latency block
module ipf_input_check_tb import ipf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitrary value
    localparam logic [7:0] REV = 8'h5a;
    localparam logic [6:0] CTRL = PARITY_CONTROL_ADDR;
    localparam logic [6:0] RISE = RISING_PARITY_ERROR_COUNT_ADDR;
    localparam logic [6:0] FALL = FALLING_PARITY_ERROR_COUNT_ADDR;

    logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, even_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic s_valid_i, s_parity_i, s_ready_o, dac_valid_o, dac_ready_i;
    logic [15:0] s_data_i, dac_data_o, q1_falling_compare_word_o;
    logic frame_i, sync_i, interp2_i, depth_reset_i, read_phase_o;
    logic [2:0] fifo_depth_i;
    logic [3:0] fifo_level_o;
    logic rising_parity_fault_o, falling_parity_fault_o;
    logic [15:0] got_q[$];
    int errors = 0;
    int n_tests = 0;

    ipf_input_check #(.CHIP_REVISION(REV)) u_ipf_input_check (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .s_valid_i(s_valid_i), .s_data_i(s_data_i),
        .s_parity_i(s_parity_i), .s_ready_o(s_ready_o),
        .dac_valid_o(dac_valid_o), .dac_data_o(dac_data_o),
        .dac_ready_i(dac_ready_i), .frame_i(frame_i), .sync_i(sync_i),
        .interp2_i(interp2_i), .depth_reset_i(depth_reset_i),
        .fifo_depth_i(fifo_depth_i), .fifo_level_o(fifo_level_o),
        .read_phase_o(read_phase_o),
        .rising_parity_fault_o(rising_parity_fault_o),
        .falling_parity_fault_o(falling_parity_fault_o),
        .q1_falling_compare_word_o(q1_falling_compare_word_o));

    ipf_source_model u_ipf_source_model (
        .clk_i(clk_i), .s_ready_i(s_ready_o), .even_i(even_i),
        .s_valid_o(s_valid_i), .s_data_o(s_data_i),
        .s_parity_o(s_parity_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (dac_valid_o === 1'b1 && dac_ready_i === 1'b1) begin
            got_q.push_back(dac_data_o);
        end
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stands until the next read, so it is sampled a cycle late
    task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({8'h00, reg_rdata_o}, {8'h00, exp}, "register read");
    endtask

    task automatic send(input logic [15:0] d, input logic bad);
        u_ipf_source_model.send(d, bad, 0);
    endtask

    // Bit 0 drives the frame pin, bit 1 the sync pin
    task automatic pulse_ref(input logic [1:0] refs);
        @(posedge clk_i);
        frame_i <= refs[0];
        sync_i <= refs[1];
        repeat (8) @(posedge clk_i);
        frame_i <= 1'b0;
        sync_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
    endtask

    task automatic test_registers();
        reg_read(Q1_FALL_PATTERN_LOW_ADDR, PATTERN_RESET);
        reg_read(Q1_FALL_PATTERN_HIGH_ADDR, PATTERN_RESET);
        reg_read(CTRL, PARITY_CONTROL_RESET);
        reg_read(RISE, COUNT_RESET);
        reg_read(FALL, COUNT_RESET);
        reg_read(CHIP_REVISION_ADDR, REV);
        reg_write(Q1_FALL_PATTERN_LOW_ADDR, 8'h3c);
        reg_write(Q1_FALL_PATTERN_HIGH_ADDR, 8'hc5);
        reg_write(CHIP_REVISION_ADDR, 8'h00);
        reg_write(RISE, 8'h12);
        reg_read(Q1_FALL_PATTERN_LOW_ADDR, 8'h3c);
        reg_read(Q1_FALL_PATTERN_HIGH_ADDR, 8'hc5);
        reg_read(CHIP_REVISION_ADDR, REV);
        reg_read(RISE, 8'h00);
        reg_read(7'h10, 8'h00);
        check(q1_falling_compare_word_o, 16'hc53c, "word");
    endtask

    // Words alternate rising then falling from reset onwards
    task automatic test_parity();
        send(16'h1234, 1'b1);
        send(16'h00ff, 1'b1);
        reg_read(RISE, 8'h00);
        reg_read(FALL, 8'h00);
        reg_write(CTRL, 8'h80);
        send(16'ha5a5, 1'b1);
        reg_read(CTRL, 8'h81);
        send(16'h0001, 1'b1);
        reg_read(CTRL, 8'h83);
        send(16'h7777, 1'b0);
        send(16'h8001, 1'b0);
        reg_read(RISE, 8'h01);
        reg_read(FALL, 8'h01);
        reg_write(CTRL, 8'hc0);
        send(16'h0f0f, 1'b0);
        even_i <= 1'b1;
        send(16'h0f0e, 1'b0);
        reg_read(RISE, 8'h02);
        reg_read(FALL, 8'h01);
        check({14'h0, falling_parity_fault_o, rising_parity_fault_o},
            16'h0003, "fault pins");
        reg_write(CTRL, 8'he0);
        reg_read(CTRL, 8'hc0);
        reg_read(RISE, 8'h00);
        reg_read(FALL, 8'h00);
    endtask

    task automatic test_saturation();
        for (int i = 0; i < 258; i++) begin
            send(i[15:0], 1'b1);
            send(~i[15:0], 1'b1);
        end
        reg_read(RISE, COUNT_MAX);
        reg_read(FALL, COUNT_MAX);
        reg_write(CTRL, 8'he0);
        reg_write(CTRL, 8'h00);
    endtask

    // Fill until refused, drain in order, then realign both pointer sides
    task automatic test_fifo();
        @(posedge clk_i);
        dac_ready_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        got_q.delete();
        for (int i = 0; i < 9; i++) begin
            u_ipf_source_model.send(16'h0100 + i[15:0], 1'b0, i % 3);
        end
        repeat (3) @(posedge clk_i);
        #1;
        check({15'h0, s_ready_o}, 16'h0000, "ready when full");
        check({12'h0, fifo_level_o}, 16'h0008, "full level");
        @(posedge clk_i);
        dac_ready_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        check(16'(got_q.size()), 16'h0009, "words out");
        for (int i = 0; i < 9; i++) begin
            check(got_q[i], 16'h0100 + i[15:0], "order");
        end
        @(posedge clk_i);
        dac_ready_i <= 1'b0;
        fifo_depth_i <= 3'h3;
        for (int i = 0; i < 5; i++) begin
            send(16'h0200 + i[15:0], 1'b0);
        end
        // A lone side reset from stale pointers would leave the level
        // beyond the slot count, so both sides are aligned together first
        pulse_ref(2'b11);
        check({12'h0, fifo_level_o}, 16'h0003, "sync level");
        pulse_ref(2'b01);
        pulse_ref(2'b10);
        check({12'h0, fifo_level_o}, 16'h0003, "one side");
        @(posedge clk_i);
        depth_reset_i <= 1'b1;
        fifo_depth_i <= 3'h0;
        @(posedge clk_i);
        depth_reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({12'h0, fifo_level_o}, 16'h0004, "depth reset");
    endtask

    // In half-rate mode only every other cycle may pop a word
    task automatic test_interp();
        int n;
        logic p;
        for (int i = 0; i < 4; i++) begin
            send(16'h0300 + i[15:0], 1'b0);
        end
        @(posedge clk_i);
        interp2_i <= 1'b1;
        dac_ready_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        n = got_q.size();
        p = read_phase_o;
        @(posedge clk_i);
        #1;
        check({15'h0, read_phase_o}, {15'h0, ~p}, "read phase");
        repeat (7) @(posedge clk_i);
        #1;
        check(16'(got_q.size() - n), 16'h0004, "half rate");
        @(posedge clk_i);
        interp2_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        check({12'h0, fifo_level_o}, 16'h0000, "drained");
    endtask

    initial begin
        rst_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = 8'h00;
        dac_ready_i = 1'b1;
        frame_i = 1'b0;
        sync_i = 1'b0;
        interp2_i = 1'b0;
        depth_reset_i = 1'b0;
        fifo_depth_i = 3'h4;
        even_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_registers();
        test_parity();
        test_saturation();
        test_fifo();
        test_interp();
        give_verdict();
    end

    // The sequence needs about 1300 cycles; this allows far more
    initial begin
        #100000;
        errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
